// [sim/pbi_register_access_map_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pbi_register_access_map_tb_top;
  logic        core_clk;
  logic        nrst;
  logic [15:0] cpu_addr;
  logic        cpu_wr;
  logic        cpu_rd;
  logic [7:0]  cpu_wdata;
  logic        cpu_req_ready;
  logic        cpu_rd_valid;
  logic [7:0]  cpu_rd_data;
  logic        cpu_rd_ready;
  logic        host_cs_n;
  logic        host_oe_n;
  logic        host_we_n;
  logic [2:0]  host_reg_select;
  logic [7:0]  ddb_in;
  logic [7:0]  ddb_out;
  logic        ddb_oe;
  int          bad_count;
  int          tests_run;
  int          seed;
  int          m [int];
  logic [7:0]  exp_q [$];
  bit          io, hs, dp, bba, bbb, dwa, dwb;
  int          rl [7] = '{'hc3, 'hc4, 'hf0, 'hf1, 'hf6, 'hf8, 'hfa};
  int          il [8] = '{'hf4, 'hf5, 'hf6, 'hf7, 'hf8, 'hf9, 'hfa, 'hfb};
  pbrm_top pbrm_top_i (.core_clk(core_clk), .nrst(nrst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_req_ready(cpu_req_ready),
    .cpu_rd_valid(cpu_rd_valid), .cpu_rd_data(cpu_rd_data), .cpu_rd_ready(cpu_rd_ready),
    .host_cs_n(host_cs_n), .host_oe_n(host_oe_n), .host_we_n(host_we_n),
    .host_reg_select(host_reg_select), .ddb_in(ddb_in), .ddb_out(ddb_out), .ddb_oe(ddb_oe));
  pbrm_host_model pbrm_host_model_i (.core_clk(core_clk), .host_cs_n(host_cs_n),
    .host_oe_n(host_oe_n), .host_we_n(host_we_n), .host_reg_select(host_reg_select),
    .ddb_in(ddb_in), .ddb_out(ddb_out), .ddb_oe(ddb_oe));
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  // ****************
  // Reference model
  // ****************
  function automatic void upd_mode();
    io = !m['hc4][7];
    hs = !io && m['hf1][7];
    dp = !io && !m['hf1][7];
    bba = dp && m['hf1][6];
    bbb = dp && m['hf1][5];
    dwa = dp && !m['hf1][6];
    dwb = dp && !m['hf1][5];
  endfunction
  function automatic bit cpu_w_ok(int a);
    case (a)
      'hc3, 'hc4, 'hf1: return 1;
      'hf0: return !io;
      'hf5: return io || bba || bbb;
      'hf6, 'hf7: return !hs && !dwa;
      'hf4: return !hs && !dwb;
      'hf8, 'hf9, 'hfa, 'hfb: return io;
      'hfe: return dwa;
      'hff: return dwa || hs;
      default: return 0;
    endcase
  endfunction
  function automatic logic [7:0] cpu_r_exp(int a);
    case (a)
      'hf0: return io ? 8'h00 : m[a][7:0];
      'hf1: return m[a][7:0] | 8'h03;
      'hfc: return dwb ? m[a][7:0] : 8'h00;
      'hfd: return (dwb || hs) ? m[a][7:0] : 8'h00;
      default: return m.exists(a) ? m[a][7:0] : 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] host_r_exp(int s);
    case (s)
      0: return io ? 8'h00 : m['hf0][7:0];
      1: return dp ? m[1][7:0] : 8'h00;
      2: return bba ? m['hf6][7:0] : 8'h00;
      3: return bba ? m['hf7][7:0] : 8'h00;
      6: return dp ? m['hfe][7:0] : 8'h00;
      7: return !io ? m['hff][7:0] : 8'h00;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] rnd8();
    logic [31:0] r;
    r = $random(seed);
    return r[7:0];
  endfunction
  // ****************
  // Checks and drivers
  // ****************
  task automatic check_cpu(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD cpu t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_host(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD host t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge core_clk) begin
    if (nrst === 1'b1 && cpu_rd_valid === 1'b1 && cpu_rd_ready === 1'b1) begin
      check_cpu(cpu_rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    end
  end
  task automatic do_reset();
    @(negedge core_clk);
    nrst = 0;
    repeat (5) @(negedge core_clk);
    nrst = 1;
    m.delete();
    m['hc3] = 'h1c;
    m['hc4] = 'h09;
    m['hf0] = 'h04;
    m['hf1] = 'h03;
    m['hf6] = 'h00;
    m['hf8] = 'h00;
    m['hfa] = 'h00;
    upd_mode();
  endtask
  task automatic cpu_write(input int a, input logic [7:0] d);
    @(negedge core_clk);
    cpu_addr = {8'hff, a[7:0]};
    cpu_wdata = d;
    cpu_wr = 1;
    @(negedge core_clk);
    cpu_wr = 0;
    if (cpu_w_ok(a)) begin
      m[a] = d;
      if (a == 'hf7) m['hf2] = d;
      if (a == 'hf9) m['hf3] = d;
      upd_mode();
    end
  endtask
  task automatic cpu_read(input int a);
    int n;
    @(negedge core_clk);
    cpu_addr = {8'hff, a[7:0]};
    cpu_rd = 1;
    n = 0;
    while (cpu_req_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    exp_q.push_back(cpu_r_exp(a));
    @(negedge core_clk);
    cpu_rd = 0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    check_cpu(8'(exp_q.size()), 8'h00);
  endtask
  task automatic mw(input int s, input logic [7:0] d);
    pbrm_host_model_i.host_write(s[2:0], d);
    case (s)
      0: if (!io) m['hf0] = d;
      1: if (dp) m[1] = d;
      2: if (bbb) m['hf8] = d;
      3: if (bbb) m['hf9] = d;
      4: if (dp) m['hfc] = d;
      5: if (!io) m['hfd] = d;
      default: ;
    endcase
  endtask
  task automatic hchk(input int s);
    logic [7:0] d;
    logic       oe;
    pbrm_host_model_i.host_read(s[2:0], d, oe);
    check_host(d, host_r_exp(s));
    check_host({7'h0, oe}, 8'h01);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    bad_count = 0;
    tests_run = 0;
    seed = 51641;
    nrst = 0;
    cpu_addr = 16'h0000;
    cpu_wr = 0;
    cpu_rd = 0;
    cpu_wdata = 8'h00;
    cpu_rd_ready = 1;
    do_reset();
    foreach (rl[i]) cpu_read(rl[i]);
    foreach (il[i]) begin
      cpu_write(il[i], rnd8());
      cpu_read(il[i]);
    end
    for (int a = 'hfc; a <= 'hff; a++) cpu_write(a, rnd8());
    cpu_write('hf2, rnd8());
    cpu_write('hc0, rnd8());
    cpu_write('hf0, rnd8());
    cpu_read('hf2);
    cpu_read('hfd);
    cpu_read('hc0);
    hchk(7);
    drain();
    // Buffer holds two words while the consumer stalls
    cpu_rd_ready = 0;
    cpu_read('hf8);
    cpu_read('hfa);
    check_cpu({7'h0, cpu_req_ready}, 8'h00);
    @(negedge core_clk);
    cpu_rd_ready = 1;
    drain();
    // Direct word on both channels
    cpu_write('hc4, 8'h89);
    mw(4, rnd8());
    mw(5, rnd8());
    mw(1, rnd8());
    mw(0, rnd8());
    cpu_read('hfc);
    cpu_read('hfd);
    cpu_read('hf0);
    hchk(1);
    hchk(0);
    hchk(2);
    cpu_write('hfe, rnd8());
    cpu_write('hff, rnd8());
    hchk(6);
    hchk(7);
    repeat (4) @(negedge core_clk);
    check_host({7'h0, ddb_oe}, 8'h00);
    foreach (il[i]) if (i < 3) cpu_write(il[i], rnd8());
    foreach (il[i]) if (i < 3) cpu_read(il[i]);
    drain();
    // Handshake
    cpu_write('hf1, 8'h80);
    cpu_read('hf1);
    mw(4, rnd8());
    mw(5, rnd8());
    cpu_read('hfc);
    cpu_read('hfd);
    cpu_write('hfe, rnd8());
    cpu_write('hff, rnd8());
    hchk(6);
    hchk(7);
    mw(1, rnd8());
    hchk(1);
    foreach (il[i]) if (i < 2) cpu_write(il[i], rnd8());
    foreach (il[i]) if (i < 2) cpu_read(il[i]);
    drain();
    // Bound buffer on both channels
    cpu_write('hf1, 8'h60);
    cpu_write('hf6, rnd8());
    cpu_write('hf7, rnd8());
    hchk(2);
    hchk(3);
    mw(2, rnd8());
    mw(3, rnd8());
    mw(4, rnd8());
    cpu_read('hf8);
    cpu_read('hf9);
    cpu_read('hf2);
    cpu_read('hfc);
    drain();
    // Reset in mid-run
    do_reset();
    foreach (rl[i]) cpu_read(rl[i]);
    hchk(0);
    drain();
    finish_test();
  end
endmodule // pbi_register_access_map_tb_top
`default_nettype wire

// [sim/pbrm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pbrm_host_model (
  // Clock
  input  wire logic       core_clk,
  // Parallel port pins
  output var logic        host_cs_n,
  output var logic        host_oe_n,
  output var logic        host_we_n,
  output var logic [2:0]  host_reg_select,
  output logic     [7:0]  ddb_in,
  input  wire logic [7:0] ddb_out,
  input  wire logic       ddb_oe
);
  logic       drive;
  logic [7:0] wdat;
  logic [7:0] junk;
  initial begin
    host_cs_n = 1;
    host_oe_n = 1;
    host_we_n = 1;
    host_reg_select = 3'h0;
    drive = 0;
    wdat = 8'h00;
    junk = 8'h5a;
  end
  // Released bus toggles so a stale value never passes
  always @(posedge core_clk) junk <= ~junk;
  assign ddb_in = drive ? wdat : junk;
  task automatic host_write(input logic [2:0] s, input logic [7:0] d);
    @(negedge core_clk);
    host_cs_n = 0;
    host_reg_select = s;
    wdat = d;
    drive = 1;
    host_we_n = 0;
    repeat (3) @(negedge core_clk);
    host_we_n = 1;
    repeat (5) @(negedge core_clk);
    host_cs_n = 1;
    drive = 0;
  endtask
  task automatic host_read(input logic [2:0] s, output logic [7:0] d, output logic oe);
    @(negedge core_clk);
    host_cs_n = 0;
    host_reg_select = s;
    host_oe_n = 0;
    repeat (5) @(negedge core_clk);
    oe = ddb_oe;
    d = ddb_out;
    host_oe_n = 1;
    host_cs_n = 1;
  endtask
endmodule // pbrm_host_model
`default_nettype wire

// [verilog/pbrm_pkg.sv]
// Contract
// - Select 001 is probe, query mode only
// - Select 010 reaches channel A/B control
// - Select 011 reaches channel A/B address
// - Select 100 is high host-write data
// - Select 101 is low host-write data
// - Select 110 is high host-read data
// - Select 111 is low host-read data
// - Upper address internal only, not DW/HS
// - Channel A reload address internal read-only
// - Channel B compare internal, not DW/HS
// - Channel C control internal, resets zero
// - Access follows mode; I/O blocks link regs
`default_nettype none
package pbrm_pkg;
  // ****************
  // Internal offsets
  // ****************
  localparam logic [15:0] OFS_STC      = 16'hffc3;
  localparam logic [15:0] OFS_SYS      = 16'hffc4;
  localparam logic [15:0] OFS_LINK     = 16'hfff0;
  localparam logic [15:0] OFS_PMC      = 16'hfff1;
  localparam logic [15:0] OFS_RLD_A    = 16'hfff2;
  localparam logic [15:0] OFS_RLD_B    = 16'hfff3;
  localparam logic [15:0] OFS_CMP_B    = 16'hfff4;
  localparam logic [15:0] OFS_UPPER    = 16'hfff5;
  localparam logic [15:0] OFS_CTL_A    = 16'hfff6;
  localparam logic [15:0] OFS_ADR_A    = 16'hfff7;
  localparam logic [15:0] OFS_CTL_B    = 16'hfff8;
  localparam logic [15:0] OFS_ADR_B    = 16'hfff9;
  localparam logic [15:0] OFS_CTL_C    = 16'hfffa;
  localparam logic [15:0] OFS_ADR_C    = 16'hfffb;
  localparam logic [15:0] OFS_HW_HI    = 16'hfffc;
  localparam logic [15:0] OFS_HW_LO    = 16'hfffd;
  localparam logic [15:0] OFS_HR_HI    = 16'hfffe;
  localparam logic [15:0] OFS_HR_LO    = 16'hffff;
  // ****************
  // Select codes
  // ****************
  localparam logic [2:0]  SEL_LINK     = 3'h0;
  localparam logic [2:0]  SEL_PROBE    = 3'h1;
  localparam logic [2:0]  SEL_CTL      = 3'h2;
  localparam logic [2:0]  SEL_ADR      = 3'h3;
  localparam logic [2:0]  SEL_HW_HI    = 3'h4;
  localparam logic [2:0]  SEL_HW_LO    = 3'h5;
  localparam logic [2:0]  SEL_HR_HI    = 3'h6;
  localparam logic [2:0]  SEL_HR_LO    = 3'h7;
  // ****************
  // Reset values and fields
  // ****************
  localparam logic [7:0]  RST_STC      = 8'h1c;
  localparam logic [7:0]  RST_SYS      = 8'h09;
  localparam logic [7:0]  RST_LINK     = 8'h04;
  localparam logic [7:0]  RST_PMC      = 8'h03;
  localparam logic [7:0]  RST_CTL      = 8'h00;
  localparam logic [1:0]  PMC_FIXED    = 2'h3;
  localparam int          SYS_DPME_BIT = 7;
  localparam int          PMC_HSCE_BIT = 7;
  localparam int          PMC_DPEA_BIT = 6;
  localparam int          PMC_DPEB_BIT = 5;
  localparam int          PMC_LOW_BIT  = 2;
endpackage
`default_nettype wire

// [verilog/pbrm_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pbrm_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Internal CPU register access
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic             cpu_req_ready,
  output logic             cpu_rd_valid,
  output logic [7:0]       cpu_rd_data,
  input  wire logic        cpu_rd_ready,
  // Master CPU parallel port pins
  input  wire logic        host_cs_n,
  input  wire logic        host_oe_n,
  input  wire logic        host_we_n,
  input  wire logic [2:0]  host_reg_select,
  input  wire logic [7:0]  ddb_in,
  output logic [7:0]       ddb_out,
  output logic             ddb_oe
);
  // ****************
  // Registers
  // ****************
  logic [7:0] serial_timer_control;
  logic [7:0] system_control;
  logic [7:0] link_control_status;
  logic [5:0] pmc_bits;
  logic [7:0] chan_a_reload_addr;
  logic [7:0] chan_b_reload_addr;
  logic [7:0] chan_b_compare_addr;
  logic [7:0] xfer_addr_upper;
  logic [7:0] chan_a_xfer_control;
  logic [7:0] chan_a_xfer_addr;
  logic [7:0] chan_b_xfer_control;
  logic [7:0] chan_b_xfer_addr;
  logic [7:0] chan_c_xfer_control;
  logic [7:0] chan_c_xfer_addr;
  logic [7:0] host_write_high;
  logic [7:0] host_write_low;
  logic [7:0] host_read_high;
  logic [7:0] host_read_low;
  logic [7:0] random_read_probe;
  logic [7:0] port_mode_control;
  assign port_mode_control = {pmc_bits, pbrm_pkg::PMC_FIXED};

  // ****************
  // Mode decode
  // ****************
  logic dpme;
  logic io_mode;
  logic hs_mode;
  logic dp_mode;
  logic bb_a;
  logic bb_b;
  logic dw_a;
  logic dw_b;
  assign dpme    = system_control[pbrm_pkg::SYS_DPME_BIT];
  assign io_mode = !dpme;
  assign hs_mode = dpme && port_mode_control[pbrm_pkg::PMC_HSCE_BIT];
  assign dp_mode = dpme && !port_mode_control[pbrm_pkg::PMC_HSCE_BIT];
  assign bb_a    = dp_mode && port_mode_control[pbrm_pkg::PMC_DPEA_BIT];
  assign bb_b    = dp_mode && port_mode_control[pbrm_pkg::PMC_DPEB_BIT];
  assign dw_a    = dp_mode && !port_mode_control[pbrm_pkg::PMC_DPEA_BIT];
  assign dw_b    = dp_mode && !port_mode_control[pbrm_pkg::PMC_DPEB_BIT];

  // Internal write permission per address in the current mode
  function automatic logic cpu_wr_ok(input logic [15:0] a);
    unique case (a)
      pbrm_pkg::OFS_STC, pbrm_pkg::OFS_SYS,
      pbrm_pkg::OFS_PMC:   cpu_wr_ok = 1'b1;
      pbrm_pkg::OFS_LINK:  cpu_wr_ok = dpme;
      pbrm_pkg::OFS_UPPER: cpu_wr_ok = io_mode || bb_a || bb_b;
      pbrm_pkg::OFS_CTL_A,
      pbrm_pkg::OFS_ADR_A: cpu_wr_ok = !hs_mode && !dw_a;
      pbrm_pkg::OFS_CMP_B: cpu_wr_ok = !hs_mode && !dw_b;
      pbrm_pkg::OFS_CTL_B, pbrm_pkg::OFS_ADR_B,
      pbrm_pkg::OFS_CTL_C,
      pbrm_pkg::OFS_ADR_C: cpu_wr_ok = io_mode;
      pbrm_pkg::OFS_HR_HI: cpu_wr_ok = dw_a;
      pbrm_pkg::OFS_HR_LO: cpu_wr_ok = dw_a || hs_mode;
      default:             cpu_wr_ok = 1'b0;
    endcase
  endfunction

  // Internal read value; blocked or unmapped reads give zero
  function automatic logic [7:0] cpu_read(input logic [15:0] a);
    unique case (a)
      pbrm_pkg::OFS_STC:   cpu_read = serial_timer_control;
      pbrm_pkg::OFS_SYS:   cpu_read = system_control;
      pbrm_pkg::OFS_LINK:  cpu_read = dpme ? link_control_status : 8'h00;
      pbrm_pkg::OFS_PMC:   cpu_read = port_mode_control;
      pbrm_pkg::OFS_RLD_A: cpu_read = chan_a_reload_addr;
      pbrm_pkg::OFS_RLD_B: cpu_read = chan_b_reload_addr;
      pbrm_pkg::OFS_CMP_B: cpu_read = chan_b_compare_addr;
      pbrm_pkg::OFS_UPPER: cpu_read = xfer_addr_upper;
      pbrm_pkg::OFS_CTL_A: cpu_read = chan_a_xfer_control;
      pbrm_pkg::OFS_ADR_A: cpu_read = chan_a_xfer_addr;
      pbrm_pkg::OFS_CTL_B: cpu_read = chan_b_xfer_control;
      pbrm_pkg::OFS_ADR_B: cpu_read = chan_b_xfer_addr;
      pbrm_pkg::OFS_CTL_C: cpu_read = chan_c_xfer_control;
      pbrm_pkg::OFS_ADR_C: cpu_read = chan_c_xfer_addr;
      pbrm_pkg::OFS_HW_HI: cpu_read = dw_b ? host_write_high : 8'h00;
      pbrm_pkg::OFS_HW_LO: cpu_read = (dw_b || hs_mode) ? host_write_low : 8'h00;
      default:             cpu_read = 8'h00;
    endcase
  endfunction

  // ****************
  // Pin synchronisers
  // ****************
  logic [13:0] pin_meta;
  logic [13:0] pin_sync;
  logic        we_prev;
  logic        cs_prev;
  logic [2:0]  sel_prev;
  logic [7:0]  dat_prev;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_meta <= 14'h3fff;
      pin_sync <= 14'h3fff;
      we_prev  <= 1'b1;
      cs_prev  <= 1'b1;
      sel_prev <= 3'h0;
      dat_prev <= 8'h00;
    end else begin
      pin_meta <= {host_cs_n, host_oe_n, host_we_n, host_reg_select, ddb_in};
      pin_sync <= pin_meta;
      we_prev  <= pin_sync[11];
      cs_prev  <= pin_sync[13];
      sel_prev <= pin_sync[10:8];
      dat_prev <= pin_sync[7:0];
    end
  end
  logic       cs_s;
  logic       oe_s;
  logic       we_s;
  logic [2:0] sel_s;
  assign cs_s  = !pin_sync[13];
  assign oe_s  = !pin_sync[12];
  assign we_s  = !pin_sync[11];
  assign sel_s = pin_sync[10:8];
  // Write taken at end of strobe, so data has settled
  logic hwr;
  assign hwr = !we_prev ? (we_s == 1'b0 && !cs_prev) : 1'b0;

  // ****************
  // Internal request path
  // ****************
  logic cpu_wr_en;
  logic push;
  logic pop;
  assign cpu_wr_en = cpu_wr && cpu_wr_ok(cpu_addr);
  assign push      = cpu_rd && cpu_req_ready;
  assign pop       = cpu_rd_valid && cpu_rd_ready;

  // ****************
  // Register file
  // ****************
  // defined resets
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      serial_timer_control <= pbrm_pkg::RST_STC;
      system_control       <= pbrm_pkg::RST_SYS;
      link_control_status  <= pbrm_pkg::RST_LINK;
      pmc_bits             <= pbrm_pkg::RST_PMC[7:pbrm_pkg::PMC_LOW_BIT];
      chan_a_xfer_control  <= pbrm_pkg::RST_CTL;
      chan_b_xfer_control  <= pbrm_pkg::RST_CTL;
      chan_c_xfer_control  <= pbrm_pkg::RST_CTL;
    end else begin
      if (cpu_wr_en) begin
        unique case (cpu_addr)
          pbrm_pkg::OFS_STC:  serial_timer_control <= cpu_wdata;
          pbrm_pkg::OFS_SYS:  system_control       <= cpu_wdata;
          pbrm_pkg::OFS_LINK: link_control_status  <= cpu_wdata;
          pbrm_pkg::OFS_PMC:  pmc_bits <= cpu_wdata[7:pbrm_pkg::PMC_LOW_BIT];
          pbrm_pkg::OFS_CTL_A: chan_a_xfer_control <= cpu_wdata;
          pbrm_pkg::OFS_CTL_B: chan_b_xfer_control <= cpu_wdata;
          pbrm_pkg::OFS_CTL_C: chan_c_xfer_control <= cpu_wdata;
          default: ;
        endcase
      end
      // Master write wins a same-cycle clash
      if (hwr) begin
        unique case (sel_prev)
          pbrm_pkg::SEL_LINK: if (dpme) link_control_status <= dat_prev;
          pbrm_pkg::SEL_CTL: if (bb_b) chan_b_xfer_control <= dat_prev;
          default: ;
        endcase
      end
    end
  end

  // Registers without defined reset value carry no reset
  always_ff @(posedge core_clk) begin
    if (cpu_wr_en) begin
      unique case (cpu_addr)
        pbrm_pkg::OFS_CMP_B: chan_b_compare_addr <= cpu_wdata;
        pbrm_pkg::OFS_UPPER: xfer_addr_upper <= cpu_wdata;
        pbrm_pkg::OFS_ADR_C: chan_c_xfer_addr <= cpu_wdata;
        pbrm_pkg::OFS_HR_HI: host_read_high <= cpu_wdata;
        pbrm_pkg::OFS_HR_LO: host_read_low <= cpu_wdata;
        default: ;
      endcase
    end
    if (hwr) begin
      unique case (sel_prev)
        pbrm_pkg::SEL_PROBE: if (dp_mode) random_read_probe <= dat_prev;
        pbrm_pkg::SEL_HW_HI: if (dp_mode) host_write_high <= dat_prev;
        pbrm_pkg::SEL_HW_LO: if (dpme) host_write_low <= dat_prev;
        default: ;
      endcase
    end
  end

  // Address registers and their reload copies
  always_ff @(posedge core_clk) begin
    if (cpu_wr_en && cpu_addr == pbrm_pkg::OFS_ADR_A) begin
      chan_a_xfer_addr <= cpu_wdata;
      chan_a_reload_addr <= cpu_wdata;
    end
    if (cpu_wr_en && cpu_addr == pbrm_pkg::OFS_ADR_B) begin
      chan_b_xfer_addr   <= cpu_wdata;
      chan_b_reload_addr <= cpu_wdata;
    end else if (hwr && sel_prev == pbrm_pkg::SEL_ADR && bb_b) begin
      chan_b_xfer_addr   <= dat_prev;
      chan_b_reload_addr <= dat_prev;
    end
  end

  // ****************
  // Master read drive
  // ****************
  logic [7:0] next_ddb_out;
  always_comb begin
    next_ddb_out = 8'h00;
    unique case (sel_s)
      pbrm_pkg::SEL_LINK:  if (dpme) next_ddb_out = link_control_status;
      pbrm_pkg::SEL_PROBE: if (dp_mode) next_ddb_out = random_read_probe;
      pbrm_pkg::SEL_CTL:   if (bb_a) next_ddb_out = chan_a_xfer_control;
      pbrm_pkg::SEL_ADR:   if (bb_a) next_ddb_out = chan_a_xfer_addr;
      pbrm_pkg::SEL_HR_HI: if (dp_mode) next_ddb_out = host_read_high;
      pbrm_pkg::SEL_HR_LO: if (dpme) next_ddb_out = host_read_low;
      default: ;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ddb_out <= 8'h00;
      ddb_oe  <= 1'b0;
    end else begin
      ddb_out <= next_ddb_out;
      ddb_oe  <= cs_s && oe_s;
    end
  end

  // ****************
  // Two-entry read buffer
  // ****************
  // Head is the output flop so read data comes straight off a register
  logic       tail_valid;
  logic [7:0] tail_data;
  logic [7:0] push_data;
  logic [1:0] next_count;
  assign push_data  = cpu_read(cpu_addr);
  assign next_count = 2'({1'b0, cpu_rd_valid} + {1'b0, tail_valid}
                         + {1'b0, push} - {1'b0, pop});
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cpu_rd_valid  <= 1'b0;
      tail_valid    <= 1'b0;
      cpu_req_ready <= 1'b1;
      cpu_rd_data   <= 8'h00;
    end else begin
      cpu_req_ready <= next_count != 2'd2;
      if (pop || !cpu_rd_valid) begin
        if (tail_valid) begin
          cpu_rd_data  <= tail_data;
          cpu_rd_valid <= 1'b1;
          tail_valid   <= push;
          if (push) tail_data <= push_data;
        end else begin
          cpu_rd_valid <= push;
          if (push) cpu_rd_data <= push_data;
        end
      end else if (push) begin
        tail_valid <= 1'b1;
        tail_data  <= push_data;
      end
    end
  end

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_probe_gate;
    hwr && sel_prev == pbrm_pkg::SEL_PROBE && !dp_mode |=> $stable(random_read_probe);
  endproperty
  a_probe_gate: assert property (p_probe_gate) else $error("probe written outside query");
  property p_ctl_b_master;
    hwr && sel_prev == pbrm_pkg::SEL_CTL && bb_b
      |=> chan_b_xfer_control == $past(dat_prev);
  endproperty
  a_ctl_b_master: assert property (p_ctl_b_master) else $error("channel B control missed");
  property p_adr_a_read;
    cs_s && oe_s && sel_s == pbrm_pkg::SEL_ADR && bb_a
      |=> ddb_out == $past(chan_a_xfer_addr) && ddb_oe;
  endproperty
  a_adr_a_read: assert property (p_adr_a_read) else $error("channel A address not driven");
  property p_hw_hi_hs;
    hs_mode && cpu_rd && cpu_req_ready && cpu_addr == pbrm_pkg::OFS_HW_HI && !cpu_rd_valid
      |=> cpu_rd_valid && cpu_rd_data == 8'h00;
  endproperty
  a_hw_hi_hs: assert property (p_hw_hi_hs) else $error("high write data leaked in handshake");
  property p_hw_lo_wr;
    hwr && sel_prev == pbrm_pkg::SEL_HW_LO && dpme |=> host_write_low == $past(dat_prev);
  endproperty
  a_hw_lo_wr: assert property (p_hw_lo_wr) else $error("low write data not taken");
  property p_hr_hi_hs;
    hs_mode && cpu_wr && cpu_addr == pbrm_pkg::OFS_HR_HI |=> $stable(host_read_high);
  endproperty
  a_hr_hi_hs: assert property (p_hr_hi_hs) else $error("high read data written in handshake");
  property p_hr_lo_rd;
    cs_s && oe_s && sel_s == pbrm_pkg::SEL_HR_LO && dpme
      |=> ddb_out == $past(host_read_low);
  endproperty
  a_hr_lo_rd: assert property (p_hr_lo_rd) else $error("low read data not driven");
  property p_upper_gate;
    cpu_wr && cpu_addr == pbrm_pkg::OFS_UPPER && hs_mode |=> $stable(xfer_addr_upper);
  endproperty
  a_upper_gate: assert property (p_upper_gate) else $error("upper address written in handshake");
  property p_reload_ro;
    cpu_wr && cpu_addr == pbrm_pkg::OFS_RLD_A |=> $stable(chan_a_reload_addr);
  endproperty
  a_reload_ro: assert property (p_reload_ro) else $error("reload address written");
  property p_cmp_gate;
    cpu_wr && cpu_addr == pbrm_pkg::OFS_CMP_B && hs_mode |=> $stable(chan_b_compare_addr);
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare written in handshake");
  property p_ctl_c_int;
    !(cpu_wr && cpu_addr == pbrm_pkg::OFS_CTL_C) |=> $stable(chan_c_xfer_control);
  endproperty
  a_ctl_c_int: assert property (p_ctl_c_int) else $error("channel C control changed");
  property p_link_io;
    io_mode && cpu_wr && cpu_addr == pbrm_pkg::OFS_LINK && !hwr |=> $stable(link_control_status);
  endproperty
  a_link_io: assert property (p_link_io) else $error("link register written in I/O");
  property p_reset_vals;
    @(posedge core_clk) disable iff (1'b0)
    !nrst |=> chan_a_xfer_control == 8'h00 && system_control == 8'h09 && !cpu_rd_valid;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");
  property p_no_overflow;
    cpu_rd_valid && tail_valid |-> !cpu_req_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer accepts when full");
  c_buffer_full: cover property (cpu_rd_valid && tail_valid && !cpu_rd_ready);
  c_master_write: cover property (hwr && sel_prev == pbrm_pkg::SEL_HW_HI && dp_mode);
  c_master_read: cover property (ddb_oe && sel_s == pbrm_pkg::SEL_HR_LO && hs_mode);
  c_bound_ctl: cover property (hwr && sel_prev == pbrm_pkg::SEL_CTL && bb_b);
endmodule // pbrm_top
`default_nettype wire
